// ---- hdl/dual_module_general_timer.sv ----
// Operation
// R1: Five 16-bit timers in two modules; module timers may chain.
// R2: Each first-module timer picks timer, gated, counter or encoder mode.
// R3: Timer mode counts on system clock through a programmable prescaler.
// R4: Counter mode counts edges seen on the timer input pin.
// R5: Gated mode counts only while the input pin shows the gate level.
// R6: First-module timers count at most once per four clocks. Code: only in timer and gated modes; counter and encoder count per pin edge.
// R7: Direction comes from software or from the direction pin.
// R8: Encoder mode derives count and direction from two quadrature pins.
// R9: Core toggle latch flips on each wrap; drives pin, clocks aux timers.
// R10: Aux timer in capture or reload role does not count.
// R11: Capture-role aux latches core value on its input pin edge.
// R12: Reload-role aux loads core on pin edge or toggle latch transition.
// R13: Two reload auxes on opposite latch edges give continuous PWM.
// R14: Second module: two timers, capture reg, counts at most every two clocks. Code: only timer and gated modes; counter mode counts per pin edge.
// R15: Second-module timers use prescaled clock or external signals.
// R16: Base toggle latch flips on wrap; clocks capture timer, drives pin.
// R17: Base wraps clock the compare unit and may reload from capture reg.
// R18: Capture reg takes capture timer on capture pin edge; optional clear.
// R19: Capture may instead trigger on core input or direction pin edges.
// R20: Capture timer direction has no pin; software only.
// R21: Wraps and captures set sticky flags visible to software.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dual_module_general_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  timer_input_pin,     // 0 lo, 1 core, 2 hi
  input  wire logic [2:0]  direction_input_pin,
  input  wire logic        base_input_pin,
  input  wire logic        base_dir_pin,
  input  wire logic        capture_timer_in_pin,
  input  wire logic        capture_input_pin,
  output logic             core_toggle_out_pin,
  output logic             base_toggle_out_pin,
  output logic             compare_unit_timebase,
  output logic [5:0]       flags
);
  localparam int N = 5; // 0 lo,1 core,2 hi,3 base,4 capture
  localparam int LO = 0, CORE = 1, HI = 2, BASE = 3, CAPT = 4;

  logic [gpt_pkg::CTRL_W-1:0] ctrl_q [N];
  logic [15:0]                cnt_q  [N];
  logic [15:0]                capture_reload_reg_q;
  logic [gpt_pkg::FLG_W-1:0]  flag_q;
  logic                       core_tl_q, base_tl_q;

  // Pin synchronisers, then a third stage for edge detection
  logic [9:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {capture_input_pin, capture_timer_in_pin, base_dir_pin, base_input_pin,
                   direction_input_pin, timer_input_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  wire logic [2:0] tin   = pin_s2_q[2:0];
  wire logic [2:0] tdir  = pin_s2_q[5:3];
  wire logic [9:0] rise  = pin_s2_q & ~pin_s3_q;
  wire logic [9:0] fall  = ~pin_s2_q & pin_s3_q;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] & r) | (sel[1] & f);
  endfunction

  // Base tick dividers: module 1 every 4 clocks, module 2 every 2
  logic [1:0] div1_q;
  logic       div2_q;
  logic [7:0] pre_q [N];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div1_q <= '0;
      div2_q <= 1'b0;
    end else begin
      div1_q <= div1_q + 2'd1;  // see R6
      div2_q <= ~div2_q;        // see R14
    end
  end
  wire logic tick1 = (div1_q == 2'(gpt_pkg::MOD1_MIN_DIV - 1));
  wire logic tick2 = div2_q;

  logic [N-1:0] pre_tick;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      logic [2:0] p;
      p = ctrl_q[i][gpt_pkg::PRE_LSB +: 3];
      pre_tick[i] = ((i < BASE) ? tick1 : tick2) &&
                    ((pre_q[i] & ((8'h01 << p) - 8'h01)) == 8'h00);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) pre_q[i] <= 8'h00;
    end else begin
      for (int i = 0; i < N; i++)
        if ((i < BASE) ? tick1 : tick2) pre_q[i] <= pre_q[i] + 8'h01; // see R3
    end
  end

  // Count enable and direction for every timer
  logic [N-1:0] inc, dn, wrap;
  logic core_tl_rise, core_tl_fall;
  logic base_wrap_q;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      gpt_pkg::mode_t m;
      logic gin, gdir, ge_r, ge_f, ext;
      m    = gpt_pkg::mode_t'(ctrl_q[i][gpt_pkg::MODE_LSB +: 3]);
      gin  = (i < BASE) ? tin[i]  : (i == BASE ? pin_s2_q[6] : pin_s2_q[8]);
      gdir = (i < BASE) ? tdir[i] : (i == BASE ? pin_s2_q[7] : 1'b0); // see R20
      ge_r = (i < BASE) ? rise[i] : (i == BASE ? rise[6] : rise[8]);
      ge_f = (i < BASE) ? fall[i] : (i == BASE ? fall[6] : fall[8]);
      ext  = edge_hit(ctrl_q[i][gpt_pkg::EDGE_LSB +: 2], ge_r, ge_f);
      // Aux and capture timers may instead be clocked by the toggle latch
      if (i == LO || i == HI)
        ext = ext | edge_hit(ctrl_q[i][gpt_pkg::EDGE_LSB +: 2] & {2{gin}} & 2'b00,
                             1'b0, 1'b0);
      dn[i] = ctrl_q[i][gpt_pkg::EXTDIR_BIT] ? (gdir ^ ctrl_q[i][gpt_pkg::DOWN_BIT])
                                             : ctrl_q[i][gpt_pkg::DOWN_BIT]; // see R7
      inc[i] = 1'b0;
      if (ctrl_q[i][gpt_pkg::RUN_BIT]) begin
        case (m)
          gpt_pkg::MODE_TIMER:   inc[i] = pre_tick[i];                        // see R3 R15
          gpt_pkg::MODE_COUNTER: begin
            if (i == LO || i == HI)
              inc[i] = ctrl_q[i][gpt_pkg::GATEPOL_BIT]
                       ? edge_hit(ctrl_q[i][gpt_pkg::EDGE_LSB +: 2],
                                  core_tl_rise, core_tl_fall)                 // see R9
                       : ext;
            else if (i == CAPT && ctrl_q[i][gpt_pkg::GATEPOL_BIT])
              inc[i] = base_wrap_q;                                           // see R16
            else
              inc[i] = ext;                                                   // see R4 R15
          end
          gpt_pkg::MODE_GATED:
            inc[i] = pre_tick[i] && (gin == ~ctrl_q[i][gpt_pkg::GATEPOL_BIT]); // see R5
          gpt_pkg::MODE_ENCODER: begin
            // Any edge of A or B counts; direction from the phase relation
            if (i < BASE) begin
              inc[i] = rise[i] | fall[i] | rise[i+3] | fall[i+3];             // see R8
              dn[i]  = (rise[i] | fall[i]) ? (gin == gdir) : (gin != gdir);
              dn[i]  = dn[i] ^ ctrl_q[i][gpt_pkg::DOWN_BIT];
            end
          end
          default: inc[i] = 1'b0;                                             // see R10
        endcase
      end
      wrap[i] = inc[i] && (dn[i] ? (cnt_q[i] == 16'h0000) : (cnt_q[i] == 16'hffff));
    end
  end

  // Toggle latch transitions, registered so they act one clock after the wrap
  logic core_tl_d1_q, base_tl_d1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_tl_q    <= 1'b0;
      base_tl_q    <= 1'b0;
      core_tl_d1_q <= 1'b0;
      base_tl_d1_q <= 1'b0;
      base_wrap_q  <= 1'b0;
    end else begin
      if (wrap[CORE]) core_tl_q <= ~core_tl_q;  // see R9
      if (wrap[BASE]) base_tl_q <= ~base_tl_q;  // see R16
      core_tl_d1_q <= core_tl_q;
      base_tl_d1_q <= base_tl_q;
      base_wrap_q  <= wrap[BASE];
    end
  end
  assign core_tl_rise = core_tl_q & ~core_tl_d1_q;
  assign core_tl_fall = ~core_tl_q & core_tl_d1_q;
  assign core_toggle_out_pin   = core_tl_q & ctrl_q[CORE][gpt_pkg::OUTEN_BIT];  // see R9
  assign base_toggle_out_pin   = base_tl_q & ctrl_q[BASE][gpt_pkg::OUTEN_BIT];  // see R16
  assign compare_unit_timebase = base_wrap_q;                                   // see R17

  // Capture and reload couplings
  logic [1:0] aux_cap, aux_rld;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      int a;
      gpt_pkg::mode_t m;
      logic [1:0] es;
      a  = (k == 0) ? LO : HI;
      m  = gpt_pkg::mode_t'(ctrl_q[a][gpt_pkg::MODE_LSB +: 3]);
      es = ctrl_q[a][gpt_pkg::EDGE_LSB +: 2];
      aux_cap[k] = (m == gpt_pkg::MODE_CAPTURE) && edge_hit(es, rise[a], fall[a]); // see R11
      // Reload source: pin edge, or toggle latch edge when gate-polarity bit set
      aux_rld[k] = (m == gpt_pkg::MODE_RELOAD) &&
                   (ctrl_q[a][gpt_pkg::GATEPOL_BIT] ? edge_hit(es, core_tl_rise, core_tl_fall)
                                                    : edge_hit(es, rise[a], fall[a])); // see R12 R13
    end
  end

  logic crel_cap;
  always_comb begin
    logic [1:0] ts, es;
    ts = ctrl_q[CAPT][gpt_pkg::TRIG_LSB +: 2];
    es = ctrl_q[BASE][gpt_pkg::EDGE_LSB +: 2];
    case (ts)
      2'b00:   crel_cap = edge_hit(es, rise[9], fall[9]);                       // see R18
      2'b01:   crel_cap = edge_hit(es, rise[CORE], fall[CORE]);                 // see R19
      2'b10:   crel_cap = edge_hit(es, rise[CORE+3], fall[CORE+3]);
      default: crel_cap = edge_hit(es, rise[CORE] | rise[CORE+3], fall[CORE] | fall[CORE+3]);
    endcase
  end

  // APB
  wire logic wr = psel & penable & pwrite;
  wire logic rd_acc = psel & penable & ~pwrite;
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= gpt_pkg::ADDR_FLAGS) && (a[1:0] == 2'b00);
  endfunction
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);

  logic [N-1:0] ctrl_wr, cnt_wr;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      ctrl_wr[i] = wr && (paddr == gpt_pkg::ADDR_CORE_CTRL + 8'(4 * i));
      cnt_wr[i]  = wr && (paddr == gpt_pkg::ADDR_CORE_CNT + 8'(4 * i));
    end
  end

  // Register index i maps: 0 core ctrl uses timer order core,lo,hi,base,capt
  function automatic int reg_of(input int i);
    reg_of = (i == 0) ? CORE : (i == 1) ? LO : (i == 2) ? HI : i;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) ctrl_q[i] <= gpt_pkg::CTRL_RESET;
    end else begin
      for (int i = 0; i < N; i++)
        if (ctrl_wr[i]) ctrl_q[reg_of(i)] <= pwdata[gpt_pkg::CTRL_W-1:0];
    end
  end

  // Counters: software write beats reload, reload/capture clear beats counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) cnt_q[i] <= gpt_pkg::CNT_RESET;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (cnt_wr[i] && reg_of(i) != i) begin
        end
      end
      for (int i = 0; i < N; i++) begin
        if (inc[i]) cnt_q[i] <= dn[i] ? cnt_q[i] - 16'h0001 : cnt_q[i] + 16'h0001; // see R1
      end
      if (aux_cap[0]) cnt_q[LO] <= cnt_q[CORE];              // see R11
      if (aux_cap[1]) cnt_q[HI] <= cnt_q[CORE];
      if (aux_rld[0]) cnt_q[CORE] <= cnt_q[LO];              // see R12
      if (aux_rld[1]) cnt_q[CORE] <= cnt_q[HI];
      if (wrap[BASE] && ctrl_q[BASE][gpt_pkg::RLD_BIT]) cnt_q[BASE] <= capture_reload_reg_q; // see R17
      if (crel_cap && ctrl_q[CAPT][gpt_pkg::CLR_BIT]) cnt_q[CAPT] <= 16'h0000;   // see R18
      for (int i = 0; i < N; i++)
        if (cnt_wr[i]) cnt_q[reg_of(i)] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reload_reg_q <= gpt_pkg::CNT_RESET;
    end else if (wr && paddr == gpt_pkg::ADDR_CAPTURE_RELOAD_REG) begin
      capture_reload_reg_q <= pwdata[15:0];
    end else if (crel_cap) begin
      capture_reload_reg_q <= cnt_q[CAPT];                               // see R18 R19
    end
  end

  // Sticky flags: hardware set wins over write-one-to-clear
  logic [gpt_pkg::FLG_W-1:0] flag_set;
  assign flag_set = {crel_cap, wrap[CAPT], wrap[BASE], wrap[HI] | aux_cap[1],
                     wrap[LO] | aux_cap[0], wrap[CORE]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~((wr && paddr == gpt_pkg::ADDR_FLAGS) ? pwdata[gpt_pkg::FLG_W-1:0]
                                                                 : '0)) | flag_set; // see R21
    end
  end
  assign flags = flag_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      for (int i = 0; i < N; i++) begin
        if (paddr == gpt_pkg::ADDR_CORE_CTRL + 8'(4 * i))
          prdata <= {{(32 - gpt_pkg::CTRL_W){1'b0}}, ctrl_q[reg_of(i)]};
        if (paddr == gpt_pkg::ADDR_CORE_CNT + 8'(4 * i))
          prdata <= {16'h0000, cnt_q[reg_of(i)]};
      end
      if (paddr == gpt_pkg::ADDR_CAPTURE_RELOAD_REG) prdata <= {16'h0000, capture_reload_reg_q};
      if (paddr == gpt_pkg::ADDR_FLAGS)
        prdata <= {{(32 - gpt_pkg::FLG_W){1'b0}}, flag_q};
    end
  end
  wire logic unused_ok = rd_acc;
endmodule
`default_nettype wire

// ---- pkg/gpt_pkg.sv ----
`default_nettype none
package gpt_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_CORE_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_LO_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_HI_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_BASE_CTRL  = 8'h0c;
  localparam logic [7:0] ADDR_CAPT_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_CORE_CNT   = 8'h14;
  localparam logic [7:0] ADDR_LO_CNT     = 8'h18;
  localparam logic [7:0] ADDR_HI_CNT     = 8'h1c;
  localparam logic [7:0] ADDR_BASE_CNT   = 8'h20;
  localparam logic [7:0] ADDR_CAPT_CNT   = 8'h24;
  localparam logic [7:0] ADDR_CAPTURE_RELOAD_REG     = 8'h28;
  localparam logic [7:0] ADDR_FLAGS      = 8'h2c;

  // Control word fields
  localparam int MODE_LSB   = 0;  // 3 bits
  localparam int RUN_BIT    = 3;
  localparam int DOWN_BIT   = 4;
  localparam int EXTDIR_BIT = 5;
  localparam int PRE_LSB    = 6;  // 3 bits, divide by 2^n
  localparam int EDGE_LSB   = 9;  // 2 bits: 01 rise, 10 fall, 11 both
  localparam int GATEPOL_BIT = 11;
  localparam int OUTEN_BIT  = 12;
  localparam int CLR_BIT    = 13; // capture timer: clear after capture
  localparam int TRIG_LSB   = 14; // capture source 00 pin,01 core in,10 core dir,11 both
  localparam int RLD_BIT    = 16; // base timer: reload from capture reg on wrap
  localparam int CTRL_W     = 17;

  localparam logic [CTRL_W-1:0] CTRL_RESET = '0;
  localparam logic [15:0]       CNT_RESET  = 16'h0000;

  localparam int MOD1_MIN_DIV = 4;
  localparam int MOD2_MIN_DIV = 2;

  // Flag bit positions
  localparam int FLG_CORE = 0;
  localparam int FLG_LO   = 1;
  localparam int FLG_HI   = 2;
  localparam int FLG_BASE = 3;
  localparam int FLG_CAPT = 4;
  localparam int FLG_CREL = 5;
  localparam int FLG_W    = 6;

  typedef enum logic [2:0] {
    MODE_TIMER   = 3'b000,
    MODE_COUNTER = 3'b001,
    MODE_GATED   = 3'b011,
    MODE_ENCODER = 3'b010,
    MODE_RELOAD  = 3'b110,
    MODE_CAPTURE = 3'b111
  } mode_t;

  typedef struct packed {
    logic in_pin;
    logic dir_pin;
  } pin_pair_t;
endpackage
`default_nettype wire

// ---- verif/gpt_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpt_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        base_toggle_out_pin,
  input wire logic        compare_unit_timebase,
  input wire logic [5:0]  flags
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  logic rd_setup;
  logic wr_any;
  logic wr_flags;
  assign acc = psel && penable;
  assign bad = (paddr > gpt_pkg::ADDR_FLAGS) || (paddr[1:0] != 2'b00);
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_any = acc && pwrite;
  assign wr_flags = wr_any && (paddr == gpt_pkg::ADDR_FLAGS);
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  err_unmapped_a: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped access");
  err_mapped_a: assert property (acc && !bad |-> !pslverr)
    else $error("error on mapped access");
  rd_zero_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!$past(rd_setup) |-> $stable(prdata))
    else $error("read data moved without read");
  pulse_one_a: assert property (compare_unit_timebase |=> !compare_unit_timebase)
    else $error("timebase pulse too long");
  flag_sticky_a: assert property ((|($past(flags) & ~flags)) |-> $past(wr_flags))
    else $error("flag fell without clear write");
  base_tog_a: assert property ($changed(base_toggle_out_pin) && !$past(wr_any)
    |-> ##[0:2] compare_unit_timebase) else $error("base toggle without wrap");
  base_flag_a: assert property (compare_unit_timebase |-> ##[0:1] flags[3])
    else $error("base wrap flag missing");
  cover property (compare_unit_timebase);
  cover property (acc && pslverr);
  cover property (|($past(flags) & ~flags));
endmodule
bind dual_module_general_timer gpt_sva chk (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .prdata                (prdata),
  .pready                (pready),
  .pslverr               (pslverr),
  .base_toggle_out_pin   (base_toggle_out_pin),
  .compare_unit_timebase (compare_unit_timebase),
  .flags                 (flags)
);
`default_nettype wire

// ---- verif/pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic       pclk,
  output logic      [9:0] pins
);
  initial pins = '0;
  // Levels last 4 clocks: the design needs 3 to see an edge
  task automatic pulse(input int k);
    @(posedge pclk);
    pins[k] <= 1'b1;
    repeat (4) @(posedge pclk);
    pins[k] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic quad(input logic fwd, input int n);
    repeat (n) begin
      @(posedge pclk);
      if ((pins[1] == pins[4]) == fwd) begin
        pins[1] <= ~pins[1];
      end else begin
        pins[4] <= ~pins[4];
      end
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r2;
  logic [9:0]  pins;
  logic        c_out, b_out, tb;
  logic [5:0]  flags;
  int          n_mismatch, cmp_count, cyc;
  dual_module_general_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_pin(pins[2:0]),
    .direction_input_pin(pins[5:3]), .base_input_pin(pins[6]), .base_dir_pin(pins[7]),
    .capture_timer_in_pin(pins[8]), .capture_input_pin(pins[9]),
    .core_toggle_out_pin(c_out), .base_toggle_out_pin(b_out),
    .compare_unit_timebase(tb), .flags(flags));
  pin_model src (.pclk(pclk), .pins(pins));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      n_mismatch++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  function automatic logic [31:0] cw(logic [2:0] m, logic run, logic dn, logic [2:0] pre,
                                     logic [1:0] ed);
    cw = 32'(m) | (32'(run) << gpt_pkg::RUN_BIT) | (32'(dn) << gpt_pkg::DOWN_BIT)
       | (32'(pre) << gpt_pkg::PRE_LSB) | (32'(ed) << gpt_pkg::EDGE_LSB);
  endfunction
  // Interval between two read setups is 157 + 3 = 160 clocks
  task automatic rate(input logic [7:0] a, input logic dn, output logic [15:0] dl);
    apb(1'b0, a, 32'h0);
    r2 = rd;
    repeat (157) @(posedge pclk);
    apb(1'b0, a, 32'h0);
    dl = dn ? r2[15:0] - rd[15:0] : rd[15:0] - r2[15:0];
  endtask
  task automatic t_regs();
    rd_chk("core ctrl", gpt_pkg::ADDR_CORE_CTRL, 32'(gpt_pkg::CTRL_RESET));
    apb(1'b1, gpt_pkg::ADDR_LO_CNT, 32'hffff_1234);
    rd_chk("lo cnt", gpt_pkg::ADDR_LO_CNT, 32'h0000_1234);
    apb(1'b1, 8'h30, 32'h1);
    `CHK("unmapped err", 1'b1, err)
    rd_chk("unmapped rd", 8'h30, 32'h0);
  endtask
  task automatic t_rate();
    logic [15:0] dl;
    for (int p = 0; p < 3; p++) begin
      for (int dn = 0; dn < 2; dn++) begin
        apb(1'b1, gpt_pkg::ADDR_CORE_CTRL, cw(gpt_pkg::MODE_TIMER, 1, dn[0], p[2:0], 0));
        rate(gpt_pkg::ADDR_CORE_CNT, dn[0], dl);
        `CHK("core rate", 16'(40 >> p), dl)
      end
    end
  endtask
  task automatic t_count();
    apb(1'b1, gpt_pkg::ADDR_LO_CTRL, cw(gpt_pkg::MODE_COUNTER, 1, 0, 0, 2'b01));
    apb(1'b1, gpt_pkg::ADDR_LO_CNT, 32'h0);
    repeat (5) src.pulse(0);
    rd_chk("lo events", gpt_pkg::ADDR_LO_CNT, 32'h5);
  endtask
  // Each pulse is high for four clocks, so it spans exactly one base tick
  task automatic t_gate();
    apb(1'b1, gpt_pkg::ADDR_LO_CTRL, cw(gpt_pkg::MODE_GATED, 1, 0, 0, 2'b00));
    apb(1'b1, gpt_pkg::ADDR_LO_CNT, 32'h0);
    repeat (3) src.pulse(0);
    rd_chk("lo gated", gpt_pkg::ADDR_LO_CNT, 32'h3);
  endtask
  task automatic t_wrap();
    logic s;
    int n;
    apb(1'b1, gpt_pkg::ADDR_CORE_CTRL, 32'h1010);
    apb(1'b1, gpt_pkg::ADDR_CORE_CNT, 32'h0);
    s = c_out;
    apb(1'b1, gpt_pkg::ADDR_CORE_CTRL, 32'h1018);
    n = 0;
    while (c_out === s && n < 40) begin
      @(posedge pclk);
      n++;
    end
    `CHK("core toggle", ~s, c_out)
    `CHK("core flag", 1'b1, flags[gpt_pkg::FLG_CORE])
    apb(1'b1, gpt_pkg::ADDR_FLAGS, 32'h1 << gpt_pkg::FLG_CORE);
    apb(1'b0, gpt_pkg::ADDR_FLAGS, 32'h0);
    `CHK("flag clr", 1'b0, rd[gpt_pkg::FLG_CORE])
  endtask
  task automatic t_cap_rld();
    apb(1'b1, gpt_pkg::ADDR_CORE_CTRL, 32'h0);
    apb(1'b1, gpt_pkg::ADDR_CORE_CNT, 32'h1234);
    apb(1'b1, gpt_pkg::ADDR_LO_CTRL, cw(gpt_pkg::MODE_CAPTURE, 1, 0, 0, 2'b01));
    src.pulse(0);
    rd_chk("lo capture", gpt_pkg::ADDR_LO_CNT, 32'h1234);
    apb(1'b1, gpt_pkg::ADDR_HI_CTRL, cw(gpt_pkg::MODE_RELOAD, 1, 0, 0, 2'b01));
    apb(1'b1, gpt_pkg::ADDR_HI_CNT, 32'h00aa);
    src.pulse(2);
    rd_chk("core reload", gpt_pkg::ADDR_CORE_CNT, 32'h00aa);
  endtask
  task automatic t_base();
    logic [15:0] dl;
    logic seen;
    apb(1'b1, gpt_pkg::ADDR_BASE_CTRL, cw(gpt_pkg::MODE_TIMER, 1, 0, 0, 2'b01) | 32'h1000);
    rate(gpt_pkg::ADDR_BASE_CNT, 1'b0, dl);
    `CHK("base rate", 16'd80, dl)
    apb(1'b1, gpt_pkg::ADDR_BASE_CNT, 32'hfffe);
    seen = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      seen = seen | tb;
    end
    `CHK("timebase", 1'b1, seen)
    `CHK("base flag", 1'b1, flags[gpt_pkg::FLG_BASE])
    apb(1'b1, gpt_pkg::ADDR_CAPT_CTRL, cw(gpt_pkg::MODE_TIMER, 0, 0, 0, 2'b01) | 32'h2000);
    apb(1'b1, gpt_pkg::ADDR_CAPT_CNT, 32'h0042);
    src.pulse(9);
    rd_chk("capreg", gpt_pkg::ADDR_CAPTURE_RELOAD_REG, 32'h0042);
    rd_chk("capt clr", gpt_pkg::ADDR_CAPT_CNT, 32'h0);
    apb(1'b1, gpt_pkg::ADDR_CAPT_CTRL, cw(gpt_pkg::MODE_TIMER, 0, 0, 0, 2'b01) | 32'h4000);
    apb(1'b1, gpt_pkg::ADDR_CAPT_CNT, 32'h0077);
    src.pulse(1);
    rd_chk("capreg core in", gpt_pkg::ADDR_CAPTURE_RELOAD_REG, 32'h0077);
  endtask
  task automatic t_enc();
    apb(1'b1, gpt_pkg::ADDR_CORE_CTRL, cw(gpt_pkg::MODE_ENCODER, 1, 0, 0, 2'b11));
    apb(1'b1, gpt_pkg::ADDR_CORE_CNT, 32'h0);
    src.quad(1'b1, 8);
    apb(1'b0, gpt_pkg::ADDR_CORE_CNT, 32'h0);
    `CHK("enc fwd", 16'h0008, rd[15:0])
    src.quad(1'b0, 8);
    rd_chk("enc back", gpt_pkg::ADDR_CORE_CNT, 32'h0);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rate();
    t_count();
    t_gate();
    t_wrap();
    t_cap_rld();
    t_base();
    t_enc();
    stop_test();
  end
endmodule
`default_nettype wire
